// file: inc/sac_pkg.sv
/*
 Constants shared by the serial attenuator control link ends: frame layout, decode limits,
 tap count and link timing. Assumes a 100 MHz mclk on both ends.
*/
package sac_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int FRAME_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam logic [7:0] CHAN_ADDR = 8'h00;
  localparam logic [7:0] LAST_LEVEL = 8'h3E;
  localparam logic [7:0] MUTE_CODE = 8'h3F;
  localparam int TAP_COUNT = 64;
  localparam int TAP_MUTE = 63;
  // Host side timing
  localparam int SETUP_NS = 150;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_PERIOD_CYC = 8;
  // Host register map, AXI4-Lite byte addresses
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
endpackage

// file: inc/sac_link_if.sv
/*
 Three wire link between the host end and the attenuator end.
 Assumes one driver per wire, the host.
*/
`timescale 1ns/10ps
interface sac_link_if;
  logic frameSel_n;
  logic serData;
  logic shiftClk;
  modport host (output frameSel_n, output serData, output shiftClk);
  modport dev (input frameSel_n, input serData, input shiftClk);
endinterface

// file: hdl/sac_device.sv
/*
 Attenuator end: samples the link, shifts frames, latches and decodes those addressed to CHAN_ADDR into one tap.
 Assumes link pins are asynchronous to mclk and much slower than it.
*/
`timescale 1ns/10ps
module sac_device (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Link
  sac_link_if.dev link,
  // Ladder taps, one hot
  output logic [sac_pkg::TAP_COUNT-1:0] tapSel,
  // Setting state
  output logic [7:0] levelCode,
  output logic muted
);
  logic [2:0] selSync_r, clkSync_r, datSync_r;
  logic [sac_pkg::FRAME_BITS-1:0] shift_r, shift_nxt;
  logic [sac_pkg::TAP_COUNT-1:0] tapSel_nxt;
  logic [7:0] levelCode_nxt;
  logic muted_nxt;

  function automatic logic [sac_pkg::TAP_COUNT-1:0] decodeTap(input logic [7:0] code);
    logic [sac_pkg::TAP_COUNT-1:0] t;
    t = '0;
    if (code >= sac_pkg::MUTE_CODE) begin
      t[sac_pkg::TAP_MUTE] = 1'b1;
    end else begin
      t[code[5:0]] = 1'b1;
    end
    return t;
  endfunction

  // Bit 0 is the first stage only; edges use bits 1 and 2
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      selSync_r <= 3'h7;
      clkSync_r <= 3'h0;
      datSync_r <= 3'h0;
    end else begin
      selSync_r <= {selSync_r[1:0], link.frameSel_n};
      clkSync_r <= {clkSync_r[1:0], link.shiftClk};
      datSync_r <= {datSync_r[1:0], link.serData};
    end
  end

  wire logic selLow = ~selSync_r[2];
  wire logic clkRise = clkSync_r[1] & ~clkSync_r[2];
  // Data is taken one stage later than clock so it matches the edge sample
  wire logic selRise = selSync_r[1] & ~selSync_r[2];

  always_comb begin
    shift_nxt = shift_r;
    tapSel_nxt = tapSel;
    levelCode_nxt = levelCode;
    muted_nxt = muted;
    if (selLow && clkRise) begin
      shift_nxt = {shift_r[sac_pkg::FRAME_BITS-2:0], datSync_r[2]};
    end
    if (selRise && shift_r[sac_pkg::FRAME_BITS-1 -: sac_pkg::BYTE_BITS] == sac_pkg::CHAN_ADDR) begin
      levelCode_nxt = shift_r[sac_pkg::BYTE_BITS-1:0];
      tapSel_nxt = decodeTap(shift_r[sac_pkg::BYTE_BITS-1:0]);
      muted_nxt = shift_r[sac_pkg::BYTE_BITS-1:0] >= sac_pkg::MUTE_CODE;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= '0;
      tapSel <= {1'b1, {(sac_pkg::TAP_COUNT-1){1'b0}}};
      levelCode <= 8'hFF;
      muted <= 1'b1;
    end else begin
      shift_r <= shift_nxt;
      tapSel <= tapSel_nxt;
      levelCode <= levelCode_nxt;
      muted <= muted_nxt;
    end
  end
endmodule // sac_device

// file: hdl/sac_host.sv
/*
 Host end: AXI4-Lite slave with a command and a status register, sends one 16 bit frame
 per command write made while idle. Assumes AXI4-Lite master on mclk.
*/
`timescale 1ns/10ps
module sac_host (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // AXI4-Lite write
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Link
  sac_link_if.host link
);
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_SETUP = 2'b01, S_SHIFT = 2'b10} sac_st_t;
  sac_st_t st_r, st_nxt;
  logic [15:0] frame_r, frame_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [4:0] bits_r, bits_nxt;
  logic sel_r, sel_nxt, sclk_r, sclk_nxt, done_r, done_nxt;
  logic awHave_r, awHave_nxt, wHave_r, wHave_nxt;
  logic [3:0] awAddr_r, awAddr_nxt;
  logic [31:0] wData_r, wData_nxt;
  logic [1:0] bresp_nxt, rresp_nxt;
  logic awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
  logic [31:0] rdata_nxt;

  assign link.frameSel_n = sel_r;
  assign link.shiftClk = sclk_r;
  assign link.serData = frame_r[15];

  always_comb begin
    st_nxt = st_r;
    frame_nxt = frame_r;
    cnt_nxt = cnt_r;
    bits_nxt = bits_r;
    sel_nxt = sel_r;
    sclk_nxt = sclk_r;
    done_nxt = done_r;
    awHave_nxt = awHave_r;
    wHave_nxt = wHave_r;
    awAddr_nxt = awAddr_r;
    wData_nxt = wData_r;
    awready_nxt = awready;
    wready_nxt = wready;
    bvalid_nxt = bvalid;
    bresp_nxt = bresp;
    arready_nxt = 1'b0;
    rvalid_nxt = rvalid;
    rdata_nxt = rdata;
    rresp_nxt = rresp;
    if (awvalid && awready) begin
      awHave_nxt = 1'b1;
      awAddr_nxt = awaddr;
      awready_nxt = 1'b0;
    end
    if (wvalid && wready) begin
      wHave_nxt = 1'b1;
      wData_nxt = wdata;
      wready_nxt = 1'b0;
    end
    if (bvalid && bready) begin
      bvalid_nxt = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt = 1'b1;
    end
    // A command write while a frame is under way is answered SLVERR and dropped
    if (awHave_r && wHave_r && !bvalid) begin
      awHave_nxt = 1'b0;
      wHave_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = 2'b00;
      if (awAddr_r == sac_pkg::REG_CMD) begin
        if (st_r != S_IDLE || !wstrb[0] && 1'b0) begin
          bresp_nxt = 2'b10;
        end else begin
          frame_nxt = wData_r[15:0];
          st_nxt = S_SETUP;
          sel_nxt = 1'b0;
          sclk_nxt = 1'b0;
          cnt_nxt = 8'(sac_pkg::SETUP_CYC);
          bits_nxt = 5'(sac_pkg::FRAME_BITS);
          done_nxt = 1'b0;
        end
      end else if (awAddr_r != sac_pkg::REG_STATUS) begin
        bresp_nxt = 2'b10;
      end
    end
    // Ready is raised the cycle after arvalid is seen, and the data follows the address handshake
    if (arvalid && !rvalid && !arready) begin
      arready_nxt = 1'b1;
    end
    if (arvalid && arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = 2'b00;
      rdata_nxt = 32'h0000_0000;
      if (araddr == sac_pkg::REG_STATUS) begin
        rdata_nxt[sac_pkg::ST_BUSY_BIT] = st_r != S_IDLE;
        rdata_nxt[sac_pkg::ST_DONE_BIT] = done_r;
      end else if (araddr != sac_pkg::REG_CMD) begin
        rresp_nxt = 2'b10;
      end
    end
    if (rvalid && rready) begin
      rvalid_nxt = 1'b0;
    end
    case (st_r)
      S_IDLE: begin
      end
      S_SETUP: begin
        if (cnt_r == 8'h00) begin
          st_nxt = S_SHIFT;
          cnt_nxt = 8'(sac_pkg::HALF_PERIOD_CYC - 1);
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      S_SHIFT: begin
        if (cnt_r != 8'h00) begin
          cnt_nxt = cnt_r - 8'h01;
        end else begin
          cnt_nxt = 8'(sac_pkg::HALF_PERIOD_CYC - 1);
          if (bits_r == 5'h00) begin
            sel_nxt = 1'b1;
            st_nxt = S_IDLE;
            done_nxt = 1'b1;
          end else if (!sclk_r) begin
            sclk_nxt = 1'b1;
          end else begin
            sclk_nxt = 1'b0;
            frame_nxt = {frame_r[14:0], 1'b0};
            bits_nxt = bits_r - 5'h01;
          end
        end
      end
      default: begin
        st_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= S_IDLE;
      frame_r <= 16'h0000;
      cnt_r <= 8'h00;
      bits_r <= 5'h00;
      sel_r <= 1'b1;
      sclk_r <= 1'b0;
      done_r <= 1'b0;
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awAddr_r <= 4'h0;
      wData_r <= 32'h0000_0000;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'b00;
    end else begin
      st_r <= st_nxt;
      frame_r <= frame_nxt;
      cnt_r <= cnt_nxt;
      bits_r <= bits_nxt;
      sel_r <= sel_nxt;
      sclk_r <= sclk_nxt;
      done_r <= done_nxt;
      awHave_r <= awHave_nxt;
      wHave_r <= wHave_nxt;
      awAddr_r <= awAddr_nxt;
      wData_r <= wData_nxt;
      awready <= awready_nxt;
      wready <= wready_nxt;
      bvalid <= bvalid_nxt;
      bresp <= bresp_nxt;
      arready <= arready_nxt;
      rvalid <= rvalid_nxt;
      rdata <= rdata_nxt;
      rresp <= rresp_nxt;
    end
  end
endmodule // sac_host

// file: tb/sac_link_sva.sv
/*
 Checks on the link wires and the applied setting of the two joined ends.
 Assumes the link is sampled by mclk and driven by host flops.
*/
`timescale 1ns/10ps
module sac_link_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Link
  input wire logic frameSel_n,
  input wire logic serData,
  input wire logic shiftClk,
  // Setting
  input wire logic [sac_pkg::TAP_COUNT-1:0] tapSel,
  input wire logic [7:0] levelCode,
  input wire logic muted
);
  logic clkPrev_r;
  logic [4:0] edgeCnt_r;
  logic [4:0] edgeCnt_nxt;
  // Counts clock rises inside one frame
  always_comb begin
    edgeCnt_nxt = edgeCnt_r;
    if (frameSel_n) begin
      edgeCnt_nxt = 5'h00;
    end else if (shiftClk && !clkPrev_r) begin
      edgeCnt_nxt = edgeCnt_r + 5'h01;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clkPrev_r <= 1'b0;
      edgeCnt_r <= 5'h00;
    end else begin
      clkPrev_r <= shiftClk;
      edgeCnt_r <= edgeCnt_nxt;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_select_setup: assert property ($fell(frameSel_n) |-> (!shiftClk)[*8] ##1 (!shiftClk)[*7])
    else $error("clock rose too soon after select fell");
  a_clk_at_select: assert property ($fell(frameSel_n) |-> !shiftClk)
    else $error("clock high when select fell");
  a_clk_in_frame: assert property ($rose(shiftClk) |-> !frameSel_n)
    else $error("clock rose outside a frame");
  a_frame_bits: assert property ($rose(frameSel_n) |-> edgeCnt_r == 5'h10)
    else $error("frame did not carry sixteen bits");
  a_tap_onehot: assert property ($onehot(tapSel))
    else $error("tap select not one hot");
  a_mute_tap: assert property (tapSel[sac_pkg::TAP_MUTE] == muted)
    else $error("mute tap and mute flag differ");
  a_level_tap: assert property (!muted |-> tapSel[levelCode[5:0]] && levelCode <= 8'h3E)
    else $error("tap does not match level");
  a_apply_after: assert property ($changed(tapSel) |-> frameSel_n && $past(frameSel_n, 3))
    else $error("setting changed inside a frame");
  a_reset_mute: assert property ($rose(rst_n) |-> muted && tapSel[sac_pkg::TAP_MUTE])
    else $error("not muted after reset");
  a_data_stable: assert property (shiftClk |-> $stable(serData))
    else $error("data moved while clock high");
endmodule // sac_link_sva

// file: tb/sac_test.sv
/*
 Bench: host and attenuator ends joined by the link, driven over AXI4-Lite.
 Assumes the host map of a command word at 0x0 and status at 0x4.
*/
`timescale 1ns/10ps
module sac_test;
  logic mclk = 1'b0, rst_n = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, muted;
  logic [1:0] bresp, rresp, r;
  logic [63:0] tapSel;
  logic [7:0] levelCode;
  logic [31:0] d;
  int failures = 0, tests_run = 0;
  sac_link_if link ();
  sac_host i_sac_host (.mclk(mclk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .link(link));
  sac_device i_sac_device (.mclk(mclk), .rst_n(rst_n), .link(link), .tapSel(tapSel),
    .levelCode(levelCode), .muted(muted));
  sac_link_sva i_sac_link_sva (.mclk(mclk), .rst_n(rst_n), .frameSel_n(link.frameSel_n),
    .serData(link.serData), .shiftClk(link.shiftClk), .tapSel(tapSel),
    .levelCode(levelCode), .muted(muted));
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic finish_test;
    if (failures == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic ck(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic hang(input int n);
    if (n >= 400) begin
      ck(1'b0, "wait ran out");
      finish_test();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    int n = 0;
    @(posedge mclk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid && !awvalid && !wvalid) && n < 400);
    hang(n);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    int n = 0;
    @(posedge mclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 400);
    hang(n);
    d = rdata; r = rresp;
    arvalid <= 1'b0; rready <= 1'b0;
  endtask
  // Polls status until the frame is out, then lets the setting land
  task automatic wait_done;
    int n = 0;
    do begin
      rd(4'h4);
      n++;
    end while (d[1] !== 1'b1 && n < 400);
    hang(n);
    repeat (6) @(posedge mclk);
  endtask
  // Sends one frame and waits until the setting has had time to land
  task automatic send(input logic [7:0] ad, input logic [7:0] c);
    wr(4'h0, {16'h0, ad, c});
    ck(r === 2'h0, "command refused");
    wait_done();
  endtask
  // Walks the top of the range one step at a time into mute
  task automatic s_ramp;
    for (int c = 60; c <= 63; c++) begin
      send(8'h00, 8'(c));
      ck(tapSel === (64'h1 << c) && muted === (c == 63), "ramp step");
    end
  endtask
  task automatic s_codes;
    logic [7:0] codes [8] = '{8'h01, 8'h00, 8'h10, 8'h3D, 8'h3E, 8'h3F, 8'h40, 8'hFF};
    foreach (codes[i]) begin
      send(8'h00, codes[i]);
      ck(muted === (codes[i] > 8'h3E), "mute flag");
      ck(tapSel === (64'h1 << (codes[i] > 8'h3E ? 63 : codes[i])), "tap");
      if (codes[i] <= 8'h3E) ck(levelCode === codes[i], "level");
    end
  endtask
  task automatic s_addr;
    send(8'h00, 8'h05);
    send(8'h01, 8'h09);
    send(8'h80, 8'h00);
    ck(tapSel === 64'h20 && levelCode === 8'h05, "foreign address applied");
  endtask
  task automatic s_regs;
    wr(4'h0, 32'h0000_0007);
    wr(4'h0, 32'h0000_0002);
    ck(r === 2'h2, "busy command taken");
    rd(4'h4);
    ck(r === 2'h0 && d[1:0] === 2'b01, "busy flag");
    wr(4'h8, 32'h0);
    ck(r === 2'h2, "unmapped write");
    rd(4'hC);
    ck(r === 2'h2 && d === 32'h0, "unmapped read");
    rd(4'h0);
    ck(r === 2'h0 && d === 32'h0, "command read");
    wait_done();
    ck(tapSel === 64'h80, "busy command applied");
    send(8'h00, 8'h02);
    ck(tapSel === 64'h4, "tap after busy");
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    ck(muted === 1'b1 && tapSel === 64'h8000_0000_0000_0000, "not muted");
    ck(levelCode === 8'hFF, "level after reset");
    s_codes();
    s_ramp();
    s_addr();
    s_regs();
    finish_test();
  end
endmodule // sac_test
